// ---- verilog/option_strap_startup_control.v ----
/*
 * Option strap decoder and spindle start sequencer.
 * Assumes straps are stable at power-up, rst_b is the power-on reset, and
 * the command decoder pulses start_unit_cmd and medium_write_req.
 */
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "strap_regs.vh"

module option_strap_startup_control #(
    parameter [31:0] STEP_CYC = `DELAY_STEP_CYC
)(
    // clock and reset
    input  wire               core_clk,
    input  wire               rst_b,
    // straps and bus sense
    input  wire               single_ended_force_strap,
    input  wire               delayed_start_strap,
    input  wire               motor_start_control_strap,
    input  wire               write_protect_strap,
    input  wire               parity_disable_strap,
    input  wire [`ID_W-1:0]   scsi_id,
    input  wire               diff_sense_line,
    // command side
    input  wire               start_unit_cmd,
    input  wire               medium_write_req,
    input  wire               parity_error_in,
    // register port
    input  wire [`ADDR_W-1:0] reg_addr,
    input  wire [7:0]         reg_wdata,
    input  wire               reg_wr,
    input  wire               reg_rd,
    output reg  [7:0]         reg_rdata,
    // outputs
    output reg                lvd_mode,
    output reg                spindle_on,
    output reg                write_protected,
    output reg                parity_check_en,
    output reg                parity_error_report,
    output reg                write_reject,
    output reg                id_conflict
);
    // ---------------------------------------------------------------------
    // strap capture
    // ---------------------------------------------------------------------
    wire [5:0]       straps_q;
    wire [`ID_W-1:0] id_q;
    wire             valid;
    reg              valid_d;

    strap_sampler u_sample (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .straps_in ({1'b0, single_ended_force_strap, delayed_start_strap,
                     motor_start_control_strap, write_protect_strap,
                     parity_disable_strap}),
        .id_in     (scsi_id),
        .straps_q  (straps_q),
        .id_q      (id_q),
        .valid     (valid)
    );

    wire force_q   = straps_q[`BIT_FORCE_SINGLE];
    wire delay_q   = straps_q[`BIT_DELAY];
    wire ms_q      = straps_q[`BIT_MOTOR];
    wire wp_q      = straps_q[`BIT_WPROT];
    wire par_off_q = straps_q[`BIT_PAR_OFF];

    // ---------------------------------------------------------------------
    // spindle sequencer
    // ---------------------------------------------------------------------
    reg  [1:0] state;
    reg  [1:0] next_state;
    reg        load;
    reg        soft_start;
    wire       delay_done;

    spin_delay_timer #(
        .STEP_CYC (STEP_CYC)
    ) u_delay (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .load     (load),
        .steps    (id_q),
        .done     (delay_done)
    );

    always @*
    begin
        next_state = state;
        load       = 1'b0;
        case (state)
            `SP_SAMPLE:
            begin
                if (valid_d)
                begin
                    if (ms_q)
                        next_state = `SP_WAIT_CMD;
                    else if (delay_q)
                    begin
                        next_state = `SP_DELAY;
                        load       = 1'b1;
                    end
                    else
                        next_state = `SP_RUN;
                end
            end
            `SP_DELAY:
                if (delay_done)
                    next_state = `SP_RUN;
            `SP_WAIT_CMD:
                if (start_unit_cmd || soft_start)
                    next_state = `SP_RUN;
            `SP_RUN:
                next_state = `SP_RUN;
            default:
                next_state = `SP_SAMPLE;
        endcase
    end

    // ---------------------------------------------------------------------
    // state and outputs
    // ---------------------------------------------------------------------
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state               <= `SP_SAMPLE;
            valid_d             <= 1'b0;
            spindle_on          <= 1'b0;
            lvd_mode            <= 1'b0;
            write_protected     <= 1'b0;
            parity_check_en     <= 1'b0;
            parity_error_report <= 1'b0;
            write_reject        <= 1'b0;
            id_conflict         <= 1'b0;
        end
        else
        begin
            valid_d    <= valid;
            state      <= next_state;
            spindle_on <= (next_state == `SP_RUN);
            // sense line is live; only the force strap is latched
            lvd_mode   <= valid_d & ~force_q & diff_sense_line;
            write_protected     <= valid_d & wp_q;
            parity_check_en     <= valid_d & ~par_off_q;
            parity_error_report <= valid_d & ~par_off_q & parity_error_in;
            write_reject        <= valid_d & wp_q & medium_write_req;
            id_conflict         <= valid_d & (id_q == `HOST_ID);
        end
    end

    // ---------------------------------------------------------------------
    // register port
    // ---------------------------------------------------------------------
    // software start acts like a Start Unit; only honoured while waiting
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            soft_start <= 1'b0;
            reg_rdata  <= 8'h00;
        end
        else
        begin
            soft_start <= reg_wr & (reg_addr == `REG_STATUS) & reg_wdata[`SOFT_START_BIT];
            if (reg_rd)
            begin
                case (reg_addr)
                    `REG_STRAPS:   reg_rdata <= {2'b00, straps_q};
                    `REG_STATUS:   reg_rdata <= {2'b00, id_conflict, write_protected,
                                                 lvd_mode, spindle_on, state};
                    `REG_DELAY_ID: reg_rdata <= {4'h0, id_q};
                    default:       reg_rdata <= 8'h00;
                endcase
            end
            else
                reg_rdata <= 8'h00;
        end
    end
endmodule // option_strap_startup_control

// ---- verilog/strap_regs.vh ----
/*
 * Constants for the option strap decoder and spindle start sequencer.
 * Assumes a 50 MHz core clock and straps that are stable at power-up.
 */
//
// Functional notes
// - Single-ended force strap forces single-ended transceivers, ignoring differential sense.
// - Without force strap, differential sense line selects differential or single-ended mode.
// - No delay strap and no motor strap: spindle starts right after power-up.
// - Only motor strap: spindle waits for host Start Unit command.
// - Only delay strap: start after ID times 12 seconds; ID zero at once.
// - Both straps: start only on Start Unit; ID delay ignored.
// - Write-protect strap makes whole storage write protected; absent allows writes.
// - Parity-disable strap: no parity checking and no parity error reports.
// - Parity-disable strap absent: check parity and report results to host.
// - Straps sampled once after power-up; later changes need a power cycle.
// - ID 7 wins arbitration; target ID must differ from host ID.
`ifndef STRAP_REGS_VH
`define STRAP_REGS_VH

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define CLK_HZ          50000000
`define DELAY_STEP_S    12
`define DELAY_STEP_CYC  (`DELAY_STEP_S * `CLK_HZ)

// ---------------------------------------------------------------------
// bus ids and widths
// ---------------------------------------------------------------------
`define ID_W            4
`define HOST_ID         4'h7
`define ID_ZERO         4'h0

// ---------------------------------------------------------------------
// spindle sequencer states
// ---------------------------------------------------------------------
`define SP_SAMPLE       2'h0
`define SP_DELAY        2'h1
`define SP_WAIT_CMD     2'h2
`define SP_RUN          2'h3

// ---------------------------------------------------------------------
// register map of the plain port
// ---------------------------------------------------------------------
`define ADDR_W          4
`define REG_STRAPS      4'h0
`define REG_STATUS      4'h1
`define REG_DELAY_ID    4'h2

// ---------------------------------------------------------------------
// captured strap fields and software start bit
// ---------------------------------------------------------------------
`define BIT_FORCE_SINGLE 4
`define BIT_DELAY        3
`define BIT_MOTOR        2
`define BIT_WPROT        1
`define BIT_PAR_OFF      0
`define SOFT_START_BIT   0

`endif

// ---- verilog/spin_delay_timer.v ----
/*
 * Spindle delay timer: counts a number of fixed steps, then flags done.
 * Assumes load is a one-cycle pulse from the sequencer.
 */
`timescale 1ns/1ns
`include "strap_regs.vh"

module spin_delay_timer #(
    parameter [31:0] STEP_CYC = `DELAY_STEP_CYC
)(
    // clock and reset
    input  wire             core_clk,
    input  wire             rst_b,
    // control
    input  wire             load,
    input  wire [`ID_W-1:0] steps,
    // status
    output reg              done
);
    reg [31:0]      cyc;
    reg [`ID_W-1:0] left;
    reg             busy;

    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            cyc  <= 32'h0;
            left <= `ID_ZERO;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (load)
        begin
            cyc  <= 32'h0;
            left <= steps;
            busy <= (steps != `ID_ZERO);
            done <= (steps == `ID_ZERO);
        end
        else if (busy)
        begin
            if (cyc == STEP_CYC - 32'h1)
            begin
                cyc <= 32'h0;
                if (left == 4'h1)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                left <= left - 4'h1;
            end
            else
                cyc <= cyc + 32'h1;
        end
    end
endmodule // spin_delay_timer

// ---- verilog/strap_sampler.v ----
/*
 * Captures the option straps once after reset release and holds them.
 * Assumes straps are synchronous, static levels at power-up.
 */
`timescale 1ns/1ns
`include "strap_regs.vh"

module strap_sampler (
    // clock and reset
    input  wire             core_clk,
    input  wire             rst_b,
    // raw straps
    input  wire [5:0]       straps_in,
    input  wire [`ID_W-1:0] id_in,
    // held values
    output reg  [5:0]       straps_q,
    output reg  [`ID_W-1:0] id_q,
    output reg              valid
);
    // captured by a clocked process after release, never under reset
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            // cleared so a register read right after release never shows unknowns
            straps_q <= 6'h00;
            id_q     <= `ID_ZERO;
            valid    <= 1'b0;
        end
        else if (!valid)
        begin
            straps_q <= straps_in;
            id_q     <= id_in;
            valid    <= 1'b1;
        end
    end
endmodule // strap_sampler

// ---- verif/strap_startup_asserts.sv ----
/* checker for the strap decoder and spindle sequencer outputs.
   assumes raw straps and scsi_id are held still between resets. */
`timescale 1ns/1ns
module strap_startup_asserts (
    input wire       core_clk,
    input wire       rst_b,
    input wire       delayed_start_strap,
    input wire       motor_start_control_strap,
    input wire [3:0] scsi_id,
    input wire       diff_sense_line,
    input wire       start_unit_cmd,
    input wire       medium_write_req,
    input wire       parity_error_in,
    input wire       reg_wr,
    input wire       lvd_mode,
    input wire       spindle_on,
    input wire       write_protected,
    input wire       parity_check_en,
    input wire       parity_error_report,
    input wire       write_reject,
    input wire       id_conflict
);
default clocking dc @(posedge core_clk); endclocking
default disable iff (!rst_b);
property p_lvd;
    lvd_mode |-> $past(diff_sense_line) || $past(diff_sense_line, 2);
endproperty
a_lvd: assert property (p_lvd) else $error("lvd without sense");
property p_spin_hold;
    spindle_on |=> spindle_on;
endproperty
a_spin_hold: assert property (p_spin_hold) else $error("spindle dropped");
property p_spin_cmd;
    $rose(spindle_on) && motor_start_control_strap |-> start_unit_cmd
        || $past(start_unit_cmd) || $past(start_unit_cmd, 2) || $past(reg_wr, 2);
endproperty
a_spin_cmd: assert property (p_spin_cmd) else $error("start without command");
property p_delay;
    $rose(rst_b) && delayed_start_strap && scsi_id != 4'h0 |-> !spindle_on [*8];
endproperty
a_delay: assert property (p_delay) else $error("delayed start too early");
property p_no_reject;
    !write_protected |=> !write_reject;
endproperty
a_no_reject: assert property (p_no_reject) else $error("reject unprotected");
property p_par_off;
    !parity_check_en [*2] |=> !parity_error_report;
endproperty
a_par_off: assert property (p_par_off) else $error("parity reported off");
property p_par_on;
    parity_check_en [*2] ##0 parity_error_in |=> parity_error_report;
endproperty
a_par_on: assert property (p_par_on) else $error("parity not reported");
property p_id;
    $rose(id_conflict) |-> scsi_id == 4'h7;
endproperty
a_id: assert property (p_id) else $error("bad id conflict");
property p_reject;
    medium_write_req && write_protected |=> write_reject;
endproperty
a_reject: assert property (p_reject) else $error("write not rejected");
endmodule // strap_startup_asserts
bind option_strap_startup_control strap_startup_asserts u_chk (
    .core_clk(core_clk), .rst_b(rst_b), .delayed_start_strap(delayed_start_strap),
    .motor_start_control_strap(motor_start_control_strap), .scsi_id(scsi_id),
    .diff_sense_line(diff_sense_line), .start_unit_cmd(start_unit_cmd),
    .medium_write_req(medium_write_req), .parity_error_in(parity_error_in),
    .reg_wr(reg_wr), .lvd_mode(lvd_mode), .spindle_on(spindle_on),
    .write_protected(write_protected), .parity_check_en(parity_check_en),
    .parity_error_report(parity_error_report), .write_reject(write_reject),
    .id_conflict(id_conflict));

// ---- verif/scsi_host_model.sv ----
/* host initiator model: one-cycle command and parity fault pulses.
   assumes the bench calls pulse from its main thread. */
`timescale 1ns/1ns
module scsi_host_model #(
    parameter [3:0] HOST_ID = 4'h7
)(
    input  wire core_clk,
    output reg  start_unit_cmd,
    output reg  medium_write_req,
    output reg  parity_error_in
);
initial {parity_error_in, medium_write_req, start_unit_cmd} = 3'h0;
// kind 0 start unit, 1 medium write, 2 bus parity fault
task pulse(input [1:0] kind);
    begin
        @(posedge core_clk);
        {parity_error_in, medium_write_req, start_unit_cmd} <= 3'h1 << kind;
        @(posedge core_clk);
        {parity_error_in, medium_write_req, start_unit_cmd} <= 3'h0;
    end
endtask
endmodule // scsi_host_model

// ---- verif/option_strap_startup_control_tb.sv ----
/* bench for the strap decoder: power-ups with strap sets, register reads.
   assumes the host model and a short delay step of 10 cycles. */
`timescale 1ns/1ns
module option_strap_startup_control_tb;
reg        core_clk = 1'b0;
reg        rst_b    = 1'b0;
reg  [4:0] straps; // force, delay, motor, protect, parity off
reg  [3:0] id;
reg        diff;
reg  [3:0] addr     = 4'h0;
reg  [7:0] wdata    = 8'h00;
reg        wr       = 1'b0;
reg        rd       = 1'b0;
wire [7:0] rdata;
wire       lvd, spin, wpo, pce, per, wrj, idc, su, mw, pe;
integer    fails    = 0;
integer    n_checks = 0;
always #10 core_clk = ~core_clk;
option_strap_startup_control #(.STEP_CYC(32'd10)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .single_ended_force_strap(straps[4]),
    .delayed_start_strap(straps[3]), .motor_start_control_strap(straps[2]),
    .write_protect_strap(straps[1]), .parity_disable_strap(straps[0]), .scsi_id(id),
    .diff_sense_line(diff), .start_unit_cmd(su), .medium_write_req(mw),
    .parity_error_in(pe), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .lvd_mode(lvd), .spindle_on(spin), .write_protected(wpo),
    .parity_check_en(pce), .parity_error_report(per), .write_reject(wrj),
    .id_conflict(idc));
scsi_host_model host (.core_clk(core_clk), .start_unit_cmd(su), .medium_write_req(mw),
    .parity_error_in(pe));
task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
        n_checks = n_checks + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    end
endtask
task give_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    end
endtask
// straps are only taken at power-up, so each strap set needs a fresh reset
task boot(input [4:0] s, input [3:0] i_id);
    begin
        @(posedge core_clk);
        straps <= s;
        id <= i_id;
        rst_b <= 1'b0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
    end
endtask
task rd_reg(input [3:0] a, input [7:0] exp, input string nm);
    begin
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 check(nm, rdata, exp);
    end
endtask
task wr_reg(input [3:0] a, input [7:0] d);
    begin
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    end
endtask
// spindle must come up no sooner than lo and no later than hi cycles
task wait_spin(input integer lo, input integer hi);
    integer k;
    begin
        // leave the launching edge's time step before the first look
        #1;
        for (k = 0; k < hi && spin !== 1'b1; k = k + 1)
            @(posedge core_clk) #1;
        check("spin_late", {7'h00, spin}, 8'h01);
        check("spin_early", {7'h00, k >= lo}, 8'h01);
        if (spin !== 1'b1)
            give_verdict;
    end
endtask
initial
begin
    diff <= 1'b1;
    boot(5'h00, 4'h2);
    check("lvd", lvd, 8'h01);
    check("spin", spin, 8'h01);
    check("wp", wpo, 8'h00);
    check("pce", pce, 8'h01);
    check("idc0", idc, 8'h00);
    host.pulse(2'h2);
    #1 check("per", per, 8'h01);
    host.pulse(2'h1);
    #1 check("wrj", wrj, 8'h00);
    wr_reg(4'h0, 8'hFF);
    rd_reg(4'h0, 8'h00, "straps");
    rd_reg(4'h1, 8'h0F, "status");
    rd_reg(4'h2, 8'h02, "id");
    rd_reg(4'hF, 8'h00, "unmapped");
    straps <= 5'h12;
    diff <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check("lvd_live", lvd, 8'h00);
    check("wp_late", wpo, 8'h00);
    diff <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check("se_late", lvd, 8'h01);
    boot(5'h17, 4'h7);
    check("se_lvd", lvd, 8'h00);
    check("wp_on", wpo, 8'h01);
    check("pce_off", pce, 8'h00);
    check("idc", idc, {7'h00, id == host.HOST_ID});
    host.pulse(2'h2);
    #1 check("per_off", per, 8'h00);
    host.pulse(2'h1);
    #1 check("wrj_on", wrj, 8'h01);
    rd_reg(4'h0, 8'h17, "straps2");
    rd_reg(4'h1, 8'h32, "status2");
    wr_reg(4'hF, 8'h01);
    repeat (20) @(posedge core_clk);
    #1 check("spin_wait", spin, 8'h00);
    host.pulse(2'h0);
    wait_spin(0, 4);
    boot(5'h08, 4'h0);
    check("spin_id0", spin, 8'h01);
    boot(5'h08, 4'h2);
    wait_spin(16, 26);
    boot(5'h0C, 4'h3);
    repeat (40) @(posedge core_clk);
    #1 check("spin_both", spin, 8'h00);
    host.pulse(2'h0);
    wait_spin(0, 4);
    boot(5'h04, 4'h5);
    wr_reg(4'h1, 8'h00);
    repeat (10) @(posedge core_clk);
    #1 check("soft_zero", spin, 8'h00);
    wr_reg(4'h1, 8'h01);
    wait_spin(1, 4);
    give_verdict;
end
endmodule // option_strap_startup_control_tb
